/* File: tpc_pkg.sv */
// tpc_pkg: constants and carrier types for the transceiver pad control block
// assumes: shared by tpc_top and tpc_sync3
package tpc_pkg;
  localparam logic [9:0] TPC_ADDR_SIG_SEL    = 10'h2f6;
  localparam int         TPC_SIG_SEL_LSB     = 4;
  localparam int         TPC_SIG_SEL_MSB     = 6;
  localparam logic [2:0] TPC_SIG_SEL_ALT     = 3'h2;
  localparam logic [7:0] TPC_SIG_SEL_RESET   = 8'h00;
  localparam int         TPC_GPIO_W          = 6;
  localparam int         TPC_ADDR_W          = 10;
  localparam int         TPC_CMD_W           = 8;
  localparam logic [7:0] TPC_CMD_WRITE       = 8'h01;
  localparam logic [7:0] TPC_CMD_READ        = 8'h02;
  localparam int         TPC_FRAME_W         = 26;
  localparam int         TPC_DATA_W          = 8;
  localparam logic [4:0] TPC_CNT_FULL        = 5'h1a;
  localparam logic [4:0] TPC_CNT_LAST_BIT    = 5'h19;
  localparam logic [4:0] TPC_CNT_LAST_ADDR   = 5'h11;

  // pad mode per pad
  typedef enum logic [2:0] {
    TPC_PAD_HIZ,
    TPC_PAD_PULL_UP,
    TPC_PAD_PULL_DOWN,
    TPC_PAD_STRONG_PULL_UP,
    TPC_PAD_DRIVE
  } tpc_pad_mode_t;

  // radio status signals routed onto the general-purpose pins
  typedef struct packed {
    logic clock_out;
    logic synth_locked;
    logic frame_check_pass;
    logic irq;
    logic rf_switch_ctrl_inv;
    logic rf_switch_ctrl;
  } tpc_status_t;

  // one general-purpose pin set
  typedef struct packed {
    logic [TPC_GPIO_W-1:0] out;
    logic [TPC_GPIO_W-1:0] oe;
  } tpc_gpio_drv_t;
endpackage

/* File: tpc_sync3.sv */
// tpc_sync3: three-flop synchroniser with change accepted on agreement
// assumes: input is asynchronous to clk_sys
`timescale 1ns/10ps
module tpc_sync3
  import tpc_pkg::*;
#(
  parameter logic INIT = 1'b1
)
(
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic d,
  output logic      q
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
    end
    else
    begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // first flop feeds only the second
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      q <= INIT;
    else if (s2_reg == s3_reg)
      q <= s3_reg;
  end
endmodule

/* File: tpc_top.sv */
// tpc_top: pad control, pin function routing and serial slave of the transceiver
// assumes: clk_sys from the crystal domain, pads resolved outside from out/oe/mode
`timescale 1ns/10ps
module tpc_top
  import tpc_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  wire logic                  serial_clk,
  input  wire logic                  serial_din,
  input  wire logic                  chip_select_n,
  input  wire logic                  reset_n,
  input  wire logic                  core_regulator_enable,
  input  wire logic                  mode_select_pin,
  input  wire tpc_status_t           radio_status,
  input  wire logic                  analog_power_req,
  input  wire logic [TPC_GPIO_W-1:0] gpio_user_out,
  input  wire logic [TPC_GPIO_W-1:0] gpio_user_oe,
  input  wire logic [TPC_GPIO_W-1:0] gpio_in,
  output logic                       serial_dout,
  output logic                       serial_dout_oe,
  output tpc_pad_mode_t              serial_dout_mode,
  output tpc_gpio_drv_t              gpio_drv,
  output tpc_pad_mode_t              gpio_mode,
  output tpc_pad_mode_t              input_pad_mode,
  output tpc_pad_mode_t              mode_pin_mode,
  output logic                       core_regulator_on,
  output logic                       analog_regulator_on,
  output logic                       deep_sleep,
  output logic                       core_reset,
  output logic [TPC_GPIO_W-1:0]      gpio_in_sync,
  output logic [7:0]                 signal_output_select_config_reg
);
  logic sclk_s;
  logic sdin_s;
  logic cs_n_s;
  logic rstn_s;
  logic regen_s;
  logic sclk_d_reg;
  logic [4:0] bit_cnt_reg;
  logic [TPC_FRAME_W-1:0] shift_reg;
  logic [TPC_DATA_W-1:0] dout_sh_reg;
  logic rd_pending_reg;

  function automatic logic [2:0] sel_field(input logic [7:0] r);
    sel_field = r[TPC_SIG_SEL_MSB:TPC_SIG_SEL_LSB];
  endfunction

  // every pin is asynchronous to clk_sys; idle levels seed the flops, except reset_n, seeded low so core reset starts asserted
  tpc_sync3 #(.INIT(1'b0)) u_sclk
  (
    .clk_sys(clk_sys),
    .rst    (rst),
    .d      (serial_clk),
    .q      (sclk_s)
  );

  tpc_sync3 #(.INIT(1'b0)) u_sdin
  (
    .clk_sys(clk_sys),
    .rst    (rst),
    .d      (serial_din),
    .q      (sdin_s)
  );

  tpc_sync3 #(.INIT(1'b1)) u_cs
  (
    .clk_sys(clk_sys),
    .rst    (rst),
    .d      (chip_select_n),
    .q      (cs_n_s)
  );

  tpc_sync3 #(.INIT(1'b0)) u_rstn
  (
    .clk_sys(clk_sys),
    .rst    (rst),
    .d      (reset_n),
    .q      (rstn_s)
  );

  tpc_sync3 #(.INIT(1'b1)) u_regen
  (
    .clk_sys(clk_sys),
    .rst    (rst),
    .d      (core_regulator_enable),
    .q      (regen_s)
  );

  genvar gi;
  generate
    for (gi = 0; gi < TPC_GPIO_W; gi++)
    begin : g_gin
      // pads idle high through their pull-up
      tpc_sync3 #(.INIT(1'b1)) u_g
      (
        .clk_sys(clk_sys),
        .rst    (rst),
        .d      (gpio_in[gi]),
        .q      (gpio_in_sync[gi])
      );
    end
  endgenerate

  assign core_reset = ~rstn_s;
  assign deep_sleep = ~regen_s;
  assign core_regulator_on = regen_s;
  // analog supplies wait on power management and drop with the synchronised regulator-enable pin
  assign analog_regulator_on = analog_power_req & regen_s;

  wire sclk_rise = sclk_s & ~sclk_d_reg;
  wire sclk_fall = ~sclk_s & sclk_d_reg;
  wire selected  = ~cs_n_s;

  // frame: 8-bit command, 10-bit address, 8-bit data, msb first; slave only
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sclk_d_reg     <= 1'b0;
      bit_cnt_reg    <= 5'h00;
      shift_reg      <= '0;
      rd_pending_reg <= 1'b0;
    end
    else
    begin
      sclk_d_reg <= sclk_s;
      if (!selected || core_reset)
      begin
        bit_cnt_reg    <= 5'h00;
        rd_pending_reg <= 1'b0;
      end
      else if (sclk_rise && bit_cnt_reg != TPC_CNT_FULL)
      begin
        shift_reg      <= {shift_reg[TPC_FRAME_W-2:0], sdin_s};
        bit_cnt_reg    <= bit_cnt_reg + 5'h01;
        rd_pending_reg <= (bit_cnt_reg == TPC_CNT_LAST_ADDR) &&
                          (shift_reg[TPC_CMD_W+TPC_ADDR_W-2 -: TPC_CMD_W] == TPC_CMD_READ);
      end
      // pending read waits for the falling edge that presents its first bit
      else if (sclk_fall)
        rd_pending_reg <= 1'b0;
    end
  end

  // register write on the last data bit
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      signal_output_select_config_reg <= TPC_SIG_SEL_RESET;
    else if (core_reset)
      signal_output_select_config_reg <= TPC_SIG_SEL_RESET;
    else if (selected && sclk_rise && bit_cnt_reg == TPC_CNT_LAST_BIT &&
             shift_reg[TPC_FRAME_W-2 -: TPC_CMD_W] == TPC_CMD_WRITE &&
             shift_reg[TPC_DATA_W+TPC_ADDR_W-2 -: TPC_ADDR_W] == TPC_ADDR_SIG_SEL)
      signal_output_select_config_reg <= {shift_reg[TPC_DATA_W-2:0], sdin_s};
  end

  // read data loads and shifts on falling clock, the master samples on rising
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      dout_sh_reg <= 8'h00;
    else if (selected && sclk_fall && rd_pending_reg)
      dout_sh_reg <= (shift_reg[TPC_ADDR_W-1:0] == TPC_ADDR_SIG_SEL) ?
                     signal_output_select_config_reg : 8'h00;
    else if (selected && sclk_fall)
      dout_sh_reg <= {dout_sh_reg[TPC_DATA_W-2:0], 1'b0};
  end

  // shifter msb drives the pin; one more flop would overrun the shortest half period
  assign serial_dout = dout_sh_reg[TPC_DATA_W-1];

  // pad modes; sleep overrides everything since the core is unpowered
  always_comb
  begin
    serial_dout_oe   = 1'b0;
    serial_dout_mode = TPC_PAD_PULL_UP;
    gpio_mode        = TPC_PAD_PULL_UP;
    input_pad_mode   = TPC_PAD_HIZ;
    mode_pin_mode    = TPC_PAD_PULL_DOWN;
    if (deep_sleep)
    begin
      serial_dout_mode = TPC_PAD_STRONG_PULL_UP;
      gpio_mode        = TPC_PAD_STRONG_PULL_UP;
      input_pad_mode   = TPC_PAD_STRONG_PULL_UP;
      mode_pin_mode    = TPC_PAD_STRONG_PULL_UP;
    end
    else if (selected && !core_reset)
    begin
      serial_dout_oe   = 1'b1;
      serial_dout_mode = TPC_PAD_DRIVE;
    end
  end

  // gpio routing, registered to keep pad outputs glitch free
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      gpio_drv <= '0;
    else if (deep_sleep || core_reset)
      gpio_drv <= '0;
    else if (sel_field(signal_output_select_config_reg) == TPC_SIG_SEL_ALT)
    begin
      gpio_drv.out <= radio_status;
      gpio_drv.oe  <= '1;
    end
    else
    begin
      gpio_drv.out <= gpio_user_out;
      gpio_drv.oe  <= gpio_user_oe;
    end
  end
endmodule

/* File: tpc_props.sv */
// tpc_props: port checks for tpc_top
// assumes: bound to tpc_top, single clk_sys domain
`timescale 1ns/10ps
module tpc_props
  import tpc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic chip_select_n,
  input wire logic reset_n,
  input wire logic core_regulator_enable,
  input wire tpc_status_t radio_status,
  input wire logic analog_power_req,
  input wire logic [TPC_GPIO_W-1:0] gpio_user_out,
  input wire logic [TPC_GPIO_W-1:0] gpio_user_oe,
  input wire logic serial_dout_oe,
  input wire tpc_pad_mode_t serial_dout_mode,
  input wire tpc_gpio_drv_t gpio_drv,
  input wire tpc_pad_mode_t gpio_mode,
  input wire tpc_pad_mode_t input_pad_mode,
  input wire tpc_pad_mode_t mode_pin_mode,
  input wire logic analog_regulator_on,
  input wire logic deep_sleep,
  input wire logic core_reset,
  input wire logic [7:0] signal_output_select_config_reg
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // awake and out of core reset, so routing is live
  logic live;
  logic alt;
  assign live = !deep_sleep && !core_reset;
  assign alt = live && signal_output_select_config_reg[6:4] == TPC_SIG_SEL_ALT;
  // six cycles covers the three-flop pin synchroniser
  a_dout_release: assert property (chip_select_n [*6] |-> !serial_dout_oe)
    else $error("dout driven");
  a_dout_pullup: assert property (
    !serial_dout_oe && !deep_sleep |-> serial_dout_mode == TPC_PAD_PULL_UP)
    else $error("dout pad mode");
  // gpio drive is registered, so it lets go one cycle after sleep starts
  a_sleep_pads: assert property (deep_sleep |->
    (!$past(deep_sleep) || gpio_drv.oe == '0) &&
    gpio_mode == TPC_PAD_STRONG_PULL_UP && input_pad_mode == TPC_PAD_STRONG_PULL_UP &&
    mode_pin_mode == TPC_PAD_STRONG_PULL_UP && serial_dout_mode == TPC_PAD_STRONG_PULL_UP)
    else $error("sleep pads");
  a_sleep_entry: assert property ((!core_regulator_enable) [*6] |-> deep_sleep)
    else $error("sleep missed");
  a_analog_gate: assert property (analog_regulator_on == (analog_power_req && !deep_sleep))
    else $error("analog gate");
  a_reset_pin: assert property ($stable(reset_n) [*6] |-> core_reset == !reset_n)
    else $error("core reset");
  a_alt_route: assert property (
    alt ##1 alt |-> gpio_drv == {$past(radio_status), 6'h3f})
    else $error("alt route");
  a_user_route: assert property (
    (live && !alt) ##1 (live && !alt) |-> gpio_drv == {$past(gpio_user_out), $past(gpio_user_oe)})
    else $error("user route");
  c_alt: cover property (alt ##1 alt);
  c_dout: cover property (serial_dout_oe);
  c_sleep: cover property (deep_sleep);
endmodule

bind tpc_top tpc_props u_props
(
  .clk_sys(clk_sys),
  .rst(rst),
  .chip_select_n(chip_select_n),
  .reset_n(reset_n),
  .core_regulator_enable(core_regulator_enable),
  .radio_status(radio_status),
  .analog_power_req(analog_power_req),
  .gpio_user_out(gpio_user_out),
  .gpio_user_oe(gpio_user_oe),
  .serial_dout_oe(serial_dout_oe),
  .serial_dout_mode(serial_dout_mode),
  .gpio_drv(gpio_drv),
  .gpio_mode(gpio_mode),
  .input_pad_mode(input_pad_mode),
  .mode_pin_mode(mode_pin_mode),
  .analog_regulator_on(analog_regulator_on),
  .deep_sleep(deep_sleep),
  .core_reset(core_reset),
  .signal_output_select_config_reg(signal_output_select_config_reg)
);

/* File: tpc_spi_host.sv */
// tpc_spi_host: behavioural spi master in place of the microcontroller
// assumes: so_pad already carries the pad pull-up
`timescale 1ns/10ps
module tpc_spi_host
  import tpc_pkg::*;
(
  input  wire logic  clk_sys,
  input  wire logic  so_pad,
  output logic       serial_clk,
  output logic       serial_din,
  output logic       chip_select_n,
  output logic [7:0] rd_data,
  output logic       rd_done
);
  initial
  begin
    {serial_clk, serial_din, rd_data, rd_done} = '0;
    chip_select_n = 1;
  end
  // clock stands low between frames; hp is the half period, at least 5
  task automatic xfer(input logic [7:0] cmd, input logic [9:0] a,
                      input logic [7:0] wd, input int hp);
    logic [25:0] f;
    f = {cmd, a, wd};
    chip_select_n = 0;
    for (int i = 25; i >= 0; i--)
    begin
      serial_din = f[i];
      repeat (hp) @(negedge clk_sys);
      serial_clk = 1;
      rd_data[i % 8] = so_pad;
      repeat (hp) @(negedge clk_sys);
      serial_clk = 0;
    end
    repeat (hp) @(negedge clk_sys);
    chip_select_n = 1;
    rd_done = cmd == TPC_CMD_READ;
    repeat (hp) @(negedge clk_sys);
    rd_done = 0;
  endtask
endmodule

/* File: tpc_testbench.sv */
// testbench: tpc_top driven through tpc_spi_host and its side pins
// assumes: package, design, host model and checker compiled first
`timescale 1ns/10ps
module testbench;
  import tpc_pkg::*;
  logic clk_sys, rst, reset_n, core_regulator_enable, analog_power_req, rd_done;
  logic serial_clk, serial_din, chip_select_n, serial_dout, serial_dout_oe;
  logic core_regulator_on, analog_regulator_on, deep_sleep, core_reset;
  logic [TPC_GPIO_W-1:0] gpio_user_out, gpio_user_oe, gpio_in, gpio_in_sync;
  logic [7:0] signal_output_select_config_reg, rd_data, d;
  tpc_status_t radio_status;
  tpc_gpio_drv_t gpio_drv;
  tpc_pad_mode_t serial_dout_mode, gpio_mode, input_pad_mode, mode_pin_mode;
  logic [7:0] exp_q[$];
  int n_fail = 0;
  int cmp_count = 0;
  wire so_pad = serial_dout_oe ? serial_dout : 1'b1;
  tpc_top dut (.mode_select_pin(1'b0), .*);
  tpc_spi_host h (.*);
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic rnd;
    {radio_status, gpio_user_out, gpio_user_oe, gpio_in} = 24'($urandom);
    analog_power_req = 1'($urandom);
  endtask
  always @(posedge rd_done) chk("read", rd_data, exp_q.pop_front());
  initial
  begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial
  begin
    #300000;
    n_fail++;
    stop_test();
  end
  initial
  begin
    rst = 1;
    reset_n = 1;
    core_regulator_enable = 1;
    analog_power_req = 0;
    {radio_status, gpio_user_out, gpio_user_oe, gpio_in} = '0;
    d = 8'($urandom(19));
    repeat (10) @(negedge clk_sys);
    rst = 0;
    repeat (8) @(negedge clk_sys);
    // last pass sets the alternate code, so routing stays on it until the reset_n test clears the register
    for (int i = 0; i < 4; i++)
    begin
      d = (i == 3) ? 8'h20 : 8'($urandom);
      h.xfer(TPC_CMD_WRITE, TPC_ADDR_SIG_SEL, d, 5 + i);
      rnd();
      repeat (3) @(negedge clk_sys);
      chk("config", signal_output_select_config_reg, d);
      chk("gpio", gpio_drv, (d[6:4] == TPC_SIG_SEL_ALT) ?
          {radio_status, 6'h3f} : {gpio_user_out, gpio_user_oe});
      chk("analog", analog_regulator_on, analog_power_req);
      exp_q.push_back(d);
      h.xfer(TPC_CMD_READ, TPC_ADDR_SIG_SEL, 8'h00, 9 - i);
    end
    $display("test routing done");
    h.xfer(TPC_CMD_WRITE, 10'h2f7, 8'h70, 5);
    exp_q.push_back(8'h00);
    h.xfer(TPC_CMD_READ, 10'h2f7, 8'h00, 5);
    chk("unmapped", signal_output_select_config_reg, 8'h20);
    $display("test unmapped done");
    core_regulator_enable = 0;
    repeat (8) @(negedge clk_sys);
    chk("sleep", {deep_sleep, core_regulator_on, gpio_drv.oe}, 8'h80);
    chk("sleep pads", input_pad_mode, TPC_PAD_STRONG_PULL_UP);
    chk("gpio in", gpio_in_sync, gpio_in);
    core_regulator_enable = 1;
    repeat (8) @(negedge clk_sys);
    $display("test sleep done");
    reset_n = 0;
    repeat (8) @(negedge clk_sys);
    chk("reset", {core_reset, signal_output_select_config_reg}, 9'h100);
    reset_n = 1;
    repeat (8) @(negedge clk_sys);
    chk("idle pads", {input_pad_mode, mode_pin_mode}, {TPC_PAD_HIZ, TPC_PAD_PULL_DOWN});
    $display("test reset pin done");
    stop_test();
  end
endmodule
